// ### pkg/pcd_pkg.sv
// Constants shared by the management register group and its serial engine
package pcd_pkg;
    localparam logic [4:0]  PCD_OFS_INT      = 5'h1b;
    localparam logic [4:0]  PCD_OFS_DIAG     = 5'h1d;
    localparam logic [4:0]  PCD_OFS_XCVR     = 5'h1e;
    localparam logic [4:0]  PCD_OFS_CTRL     = 5'h1f;
    // Arbitrary default management address of this device
    localparam logic [4:0]  PCD_PHY_ADDR     = 5'h01;
    localparam logic [1:0]  PCD_OP_READ      = 2'h2;
    localparam logic [1:0]  PCD_OP_WRITE     = 2'h1;
    localparam logic [4:0]  PCD_HDR_LAST     = 5'h0c;
    localparam logic [4:0]  PCD_DATA_BITS    = 5'h10;
    localparam logic [4:0]  PCD_WR_LAST      = 5'h11;
    localparam int          PCD_IE_LSB       = 8;
    localparam int          PCD_DIAG_EN_BIT  = 15;
    localparam int          PCD_RESULT_LSB   = 13;
    localparam int          PCD_LED_MODE_LSB = 14;
    localparam int          PCD_POL_BIT      = 13;
    localparam int          PCD_FEF_BIT      = 12;
    localparam int          PCD_MDI_BIT      = 11;
    localparam int          PCD_RLOOP_BIT    = 7;
    localparam int          PCD_XSEL_BIT     = 15;
    localparam int          PCD_ILEVEL_BIT   = 9;
    localparam logic [7:0]  PCD_IE_RST       = 8'h00;
    localparam logic [7:0]  PCD_FLAGS_RST    = 8'h00;
    localparam logic [1:0]  PCD_LED_MODE_RST = 2'h0;
    localparam logic        PCD_RLOOP_RST    = 1'b0;
    localparam logic        PCD_XSEL_RST     = 1'b1;
    localparam logic        PCD_ILEVEL_RST   = 1'b0;
    localparam logic [1:0]  PCD_LED_MODE0    = 2'h0;
    localparam logic [1:0]  PCD_LED_MODE1    = 2'h1;
    localparam logic [1:0]  PCD_LED_MODE2    = 2'h2;
endpackage : pcd_pkg

// ### pkg/pcd_reg_if.sv
// Register access strobes between the serial engine and the register group
`timescale 1ns/1ns
interface pcd_reg_if;
    logic        rd_stb;
    logic        wr_stb;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport engine (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
    modport regs   (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface : pcd_reg_if

// ### core/pcd_mdio_engine.sv
// Serial management frame engine: decodes frames, drives read data back
`timescale 1ns/1ns
module pcd_mdio_engine
    import pcd_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   reset_n,
    input  wire logic   mdc,
    input  wire logic   mdio_in,
    output logic        mdio_out,
    output logic        mdio_oe_n,
    pcd_reg_if.engine   bus
);
    typedef enum logic [2:0] {S_IDLE, S_HDR, S_TURN, S_READ, S_WRITE} pcd_state_t;

    logic        mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
    pcd_state_t  state, next_state;
    logic [4:0]  cnt, next_cnt;
    logic [17:0] shift, next_shift;
    logic [4:0]  addr, next_addr;
    logic        prev_one, next_prev_one;
    logic        drive_oe, next_drive_oe;
    logic        drive_bit, next_drive_bit;
    logic        rise;
    logic [12:0] hdr;

    // Clock takes three stages, the third for edge detection, and data two, so mdio_s2 lines up with the detected rise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2} <= 5'h1f;
        end else begin
            {mdc_s1, mdc_s2, mdc_s3} <= {mdc, mdc_s1, mdc_s2};
            {mdio_s1, mdio_s2}       <= {mdio_in, mdio_s1};
        end
    end

    assign rise      = mdc_s2 & ~mdc_s3;
    assign hdr       = {shift[11:0], mdio_s2};
    assign bus.addr  = addr;
    assign bus.wdata = shift[15:0];
    assign mdio_out  = drive_bit;
    assign mdio_oe_n = ~drive_oe;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_shift     = shift;
        next_addr      = addr;
        next_prev_one  = prev_one;
        next_drive_oe  = drive_oe;
        next_drive_bit = drive_bit;
        bus.rd_stb     = 1'b0;
        bus.wr_stb     = 1'b0;
        if (rise) begin
            case (state)
                S_IDLE: begin
                    next_prev_one = mdio_s2;
                    if (prev_one && !mdio_s2) begin
                        next_state = S_HDR;
                        next_cnt   = 5'h00;
                    end
                end
                S_HDR: begin
                    next_shift = {shift[16:0], mdio_s2};
                    next_cnt   = cnt + 5'h01;
                    if (cnt == PCD_HDR_LAST) begin
                        next_state    = S_IDLE;
                        next_prev_one = 1'b0;
                        next_addr     = hdr[4:0];
                        next_cnt      = 5'h00;
                        if (hdr[12] && hdr[9:5] == PCD_PHY_ADDR) begin
                            if (hdr[11:10] == PCD_OP_READ) begin
                                next_state = S_TURN;
                            end else if (hdr[11:10] == PCD_OP_WRITE) begin
                                next_state = S_WRITE;
                            end
                        end
                    end
                end
                S_TURN: begin
                    // Snapshot taken here; flags cleared by this read are already copied
                    bus.rd_stb     = 1'b1;
                    next_shift     = {2'h0, bus.rdata};
                    next_drive_oe  = 1'b1;
                    next_drive_bit = 1'b0;
                    next_state     = S_READ;
                end
                S_READ: begin
                    next_cnt = cnt + 5'h01;
                    if (cnt == PCD_DATA_BITS) begin
                        // Count must not land on the write index, or idle would strobe a write
                        next_cnt      = 5'h00;
                        next_drive_oe = 1'b0;
                        next_state    = S_IDLE;
                    end else begin
                        next_drive_bit = shift[15];
                        next_shift     = {shift[16:0], 1'b0};
                    end
                end
                S_WRITE: begin
                    next_shift = {shift[16:0], mdio_s2};
                    next_cnt   = cnt + 5'h01;
                    if (cnt == PCD_WR_LAST) begin
                        // Count parks on the last index so the idle cycle raises the strobe
                        next_state = S_IDLE;
                        next_cnt   = PCD_WR_LAST;
                    end
                end
                default: next_state = S_IDLE;
            endcase
        end else if (state == S_IDLE && cnt == PCD_WR_LAST) begin
            // Write strobe one cycle after the last data bit is shifted in
            bus.wr_stb = 1'b1;
            next_cnt   = 5'h00;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= S_IDLE;
            cnt       <= 5'h00;
            shift     <= 18'h00000;
            addr      <= 5'h00;
            prev_one  <= 1'b0;
            drive_oe  <= 1'b0;
            drive_bit <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            shift     <= next_shift;
            addr      <= next_addr;
            prev_one  <= next_prev_one;
            drive_oe  <= next_drive_oe;
            drive_bit <= next_drive_bit;
        end
    end
endmodule : pcd_mdio_engine

// ### core/pcd_regs.sv
// Interrupt, cable diagnostic and transceiver control register group
`timescale 1ns/1ns
module pcd_regs
    import pcd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe_n,
    input  wire logic [7:0]  event_in,
    output logic             cable_test_start,
    input  wire logic        cable_test_done,
    input  wire logic [1:0]  cable_result,
    input  wire logic [8:0]  cable_fault_count,
    input  wire logic        polarity_reversed,
    input  wire logic        far_end_fault,
    input  wire logic        mdi_state,
    input  wire logic        link_up,
    input  wire logic        activity,
    input  wire logic        full_duplex,
    input  wire logic        collision,
    input  wire logic        speed_100,
    output logic             indicator_0,
    output logic             indicator_1,
    output logic             indicator_2,
    output logic             indicator_3,
    output logic             remote_loopback,
    output logic             crossover_algorithm_select,
    output logic             intr_pin
);
    import pcd_pkg::*;

    pcd_reg_if bus ();

    pcd_mdio_engine u_engine (
        .clk       (clk),
        .reset_n   (reset_n),
        .mdc       (mdc),
        .mdio_in   (mdio_in),
        .mdio_out  (mdio_out),
        .mdio_oe_n (mdio_oe_n),
        .bus       (bus)
    );

    logic [7:0]  ie, next_ie;
    logic [7:0]  flags, next_flags;
    logic        busy, next_busy;
    logic        start, next_start;
    logic [1:0]  result, next_result;
    logic [8:0]  fault_cnt, next_fault_cnt;
    logic [1:0]  led_mode, next_led_mode;
    logic        rloop, next_rloop;
    logic        xsel, next_xsel;
    logic        ilevel, next_ilevel;
    logic        irq, next_irq;
    logic [3:0]  ind, next_ind;
    logic        wr_int, wr_diag, wr_xcvr, wr_ctrl, rd_clear, any_irq;

    assign wr_int   = bus.wr_stb && bus.addr == PCD_OFS_INT;
    assign wr_diag  = bus.wr_stb && bus.addr == PCD_OFS_DIAG;
    assign wr_xcvr  = bus.wr_stb && bus.addr == PCD_OFS_XCVR;
    assign wr_ctrl  = bus.wr_stb && bus.addr == PCD_OFS_CTRL;
    assign rd_clear = bus.rd_stb && bus.addr == PCD_OFS_INT;
    assign any_irq  = |(flags & ie);

    assign cable_test_start           = start;
    assign remote_loopback            = rloop;
    assign crossover_algorithm_select = xsel;
    assign intr_pin                   = irq;
    assign {indicator_3, indicator_2, indicator_1, indicator_0} = ind;

    // Read mux; unmapped offsets and reserved bits read as zero
    always_comb begin
        bus.rdata = 16'h0000;
        case (bus.addr)
            PCD_OFS_INT:  bus.rdata = {ie, flags};
            PCD_OFS_DIAG: begin
                bus.rdata[PCD_DIAG_EN_BIT] = busy;
                bus.rdata[PCD_RESULT_LSB +: 2] = result;
                bus.rdata[8:0] = fault_cnt;
            end
            PCD_OFS_XCVR: begin
                bus.rdata[PCD_LED_MODE_LSB +: 2] = led_mode;
                bus.rdata[PCD_POL_BIT] = polarity_reversed;
                bus.rdata[PCD_FEF_BIT] = ~far_end_fault;
                bus.rdata[PCD_MDI_BIT] = mdi_state;
                bus.rdata[PCD_RLOOP_BIT] = rloop;
            end
            PCD_OFS_CTRL: begin
                bus.rdata[PCD_XSEL_BIT] = xsel;
                bus.rdata[PCD_ILEVEL_BIT] = ilevel;
            end
            default: bus.rdata = 16'h0000;
        endcase
    end

    always_comb begin
        next_ie        = ie;
        next_busy      = busy;
        next_start     = 1'b0;
        next_result    = result;
        next_fault_cnt = fault_cnt;
        next_led_mode  = led_mode;
        next_rloop     = rloop;
        next_xsel      = xsel;
        next_ilevel    = ilevel;
        // A new event in the clearing cycle survives the read
        next_flags = (rd_clear ? PCD_FLAGS_RST : flags) | event_in;
        if (wr_int) begin
            next_ie = bus.wdata[PCD_IE_LSB +: 8];
        end
        if (wr_diag && bus.wdata[PCD_DIAG_EN_BIT] && !busy) begin
            next_busy  = 1'b1;
            next_start = 1'b1;
        end
        if (cable_test_done && busy) begin
            next_busy      = 1'b0;
            next_result    = cable_result;
            next_fault_cnt = cable_fault_count;
        end
        if (wr_xcvr) begin
            next_led_mode = bus.wdata[PCD_LED_MODE_LSB +: 2];
            next_rloop    = bus.wdata[PCD_RLOOP_BIT];
        end
        if (wr_ctrl) begin
            next_xsel   = bus.wdata[PCD_XSEL_BIT];
            next_ilevel = bus.wdata[PCD_ILEVEL_BIT];
        end
        next_irq = ilevel ? any_irq : ~any_irq;
        case (led_mode)
            PCD_LED_MODE0: next_ind = {collision, full_duplex, speed_100,
                                       link_up & ~activity};
            PCD_LED_MODE1: next_ind = {activity, full_duplex | collision,
                                       speed_100, link_up};
            PCD_LED_MODE2: next_ind = {activity, full_duplex,
                                       link_up & speed_100, link_up & ~speed_100};
            default:       next_ind = 4'h0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ie        <= PCD_IE_RST;
            flags     <= PCD_FLAGS_RST;
            busy      <= 1'b0;
            start     <= 1'b0;
            result    <= 2'h0;
            fault_cnt <= 9'h000;
            led_mode  <= PCD_LED_MODE_RST;
            rloop     <= PCD_RLOOP_RST;
            xsel      <= PCD_XSEL_RST;
            ilevel    <= PCD_ILEVEL_RST;
            irq       <= 1'b1;
            ind       <= 4'h0;
        end else begin
            ie        <= next_ie;
            flags     <= next_flags;
            busy      <= next_busy;
            start     <= next_start;
            result    <= next_result;
            fault_cnt <= next_fault_cnt;
            led_mode  <= next_led_mode;
            rloop     <= next_rloop;
            xsel      <= next_xsel;
            ilevel    <= next_ilevel;
            irq       <= next_irq;
            ind       <= next_ind;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_enable_write;
        wr_int |=> ie == $past(bus.wdata[15:8]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_flag_set;
        (|event_in) |=> (flags & $past(event_in)) == $past(event_in);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag not set");

    property p_read_clear;
        rd_clear && event_in == 8'h00 |=> flags == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flags not cleared");

    property p_irq_level;
        ##1 intr_pin == ($past(ilevel) ? $past(any_irq) : !$past(any_irq));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt pin wrong");

    property p_diag_start;
        wr_diag && bus.wdata[15] && !busy |=> cable_test_start && busy ##1 !cable_test_start;
    endproperty
    a_diag_start: assert property (p_diag_start) else $error("test start wrong");

    property p_diag_done;
        cable_test_done && busy |=> !busy && result == $past(cable_result)
            && fault_cnt == $past(cable_fault_count);
    endproperty
    a_diag_done: assert property (p_diag_done) else $error("test result not kept");

    property p_far_end;
        bus.addr == PCD_OFS_XCVR |-> bus.rdata[12] == !far_end_fault
            && bus.rdata[10:8] == 3'h0 && bus.rdata[6:0] == 7'h00;
    endproperty
    a_far_end: assert property (p_far_end) else $error("transceiver read wrong");

    property p_led_mode2;
        led_mode == PCD_LED_MODE2 |=> indicator_0 == $past(link_up & ~speed_100)
            && indicator_1 == $past(link_up & speed_100);
    endproperty
    a_led_mode2: assert property (p_led_mode2) else $error("indicator map wrong");

    property p_ctrl_write;
        wr_ctrl |=> crossover_algorithm_select == $past(bus.wdata[15]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("select write lost");
endmodule : pcd_regs

// ### dv/pcd_mgmt_host.sv
// Station management host model: drives frames on mdc and mdio
`timescale 1ns/1ns
module pcd_mgmt_host (
    input  wire logic clk,
    input  wire logic mdio_line,
    output logic      mdc,
    output logic      host_out,
    output logic      host_en
);
    // Clock stands high between frames; the line floats to the pull-up
    initial begin
        mdc      = 1'b1;
        host_out = 1'b1;
        host_en  = 1'b0;
    end

    // One mdc period is 8 clk; sampling just before the rise leaves the device 4 clk to settle
    task automatic bit_cycle(input logic drive, input logic b, output logic s);
        @(posedge clk);
        mdc      <= 1'b0;
        host_en  <= drive;
        host_out <= b;
        repeat (4) @(posedge clk);
        s = mdio_line;
        mdc <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : bit_cycle

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [31:0] word;
        logic        s;
        word = {2'b01, op, phy, reg_a, (op == 2'h2) ? 2'b11 : 2'b10, wdata};
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
        // Host lets go of the line from turnaround onward on a read
        for (int i = 31; i >= 0; i--) begin
            bit_cycle((op != 2'h2) || (i > 17), word[i], s);
            if (i < 16) rdata[i] = s;
        end
        bit_cycle(1'b0, 1'b1, s);
    endtask : frame
endmodule : pcd_mgmt_host

// ### dv/pcd_regs_tb.sv
// Self-checking bench for the interrupt, cable diagnostic and control register group
`timescale 1ns/1ns
module pcd_regs_tb;
    import pcd_pkg::*;
    logic       clk, reset_n, mdc, mdio_out, mdio_oe_n, host_out, host_en, mdio_line;
    logic [7:0] event_in;
    logic       cable_test_start, cable_test_done, polarity_reversed, far_end_fault, mdi_state;
    logic [1:0] cable_result;
    logic [8:0] cable_fault_count;
    logic       link_up, activity, full_duplex, collision, speed_100;
    logic [3:0] ind;
    logic       remote_loopback, crossover_algorithm_select, intr_pin;
    int         num_errors, num_checks, starts;

    assign mdio_line = !mdio_oe_n ? mdio_out : (host_en ? host_out : 1'b1);

    pcd_mgmt_host host_u (.clk(clk), .mdio_line(mdio_line), .mdc(mdc), .host_out(host_out),
                          .host_en(host_en));
    pcd_regs dut_u (.clk(clk), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .event_in(event_in),
        .cable_test_start(cable_test_start), .cable_test_done(cable_test_done),
        .cable_result(cable_result), .cable_fault_count(cable_fault_count),
        .polarity_reversed(polarity_reversed), .far_end_fault(far_end_fault),
        .mdi_state(mdi_state), .link_up(link_up), .activity(activity),
        .full_duplex(full_duplex), .collision(collision), .speed_100(speed_100),
        .indicator_0(ind[0]), .indicator_1(ind[1]), .indicator_2(ind[2]),
        .indicator_3(ind[3]), .remote_loopback(remote_loopback),
        .crossover_algorithm_select(crossover_algorithm_select), .intr_pin(intr_pin));

    always #10 clk = ~clk;
    always @(posedge clk) if (cable_test_start === 1'b1) starts++;

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [15:0] d,
                      input logic [4:0] phy = PCD_PHY_ADDR);
        logic [15:0] q;
        host_u.frame(PCD_OP_WRITE, phy, a, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what,
                      input logic [4:0] phy = PCD_PHY_ADDR);
        logic [15:0] q;
        host_u.frame(PCD_OP_READ, phy, a, 16'h0000, q);
        check(q, exp, what);
    endtask : rd

    task automatic pulse_event(input int i);
        @(posedge clk);
        event_in <= 8'h01 << i;
        @(posedge clk);
        event_in <= 8'h00;
        repeat (3) @(posedge clk);
    endtask : pulse_event

    task automatic test_reset;
        rd(PCD_OFS_INT, 16'h0000, "int reset");
        rd(PCD_OFS_CTRL, 16'h8000, "ctrl reset");
        rd(PCD_OFS_XCVR, 16'h1000, "xcvr reset");
        check({13'h0, intr_pin, crossover_algorithm_select, remote_loopback}, 16'h6, "pins");
    endtask : test_reset

    task automatic test_irq;
        wr(PCD_OFS_INT, 16'hff00);
        rd(PCD_OFS_INT, 16'hff00, "enables");
        for (int i = 0; i < 8; i++) begin
            pulse_event(i);
            check(intr_pin, 1'b0, "irq active low");
            rd(PCD_OFS_INT, 16'hff00 | (16'h1 << i), "event flag");
            check(intr_pin, 1'b1, "irq cleared by read");
            rd(PCD_OFS_INT, 16'hff00, "flag self clear");
        end
        wr(PCD_OFS_INT, 16'h7f00);
        pulse_event(7);
        check(intr_pin, 1'b1, "masked event");
        rd(PCD_OFS_INT, 16'h7f80, "masked flag kept");
        wr(PCD_OFS_CTRL, 16'hffff);
        rd(PCD_OFS_CTRL, 16'h8200, "ctrl bits");
        check(intr_pin, 1'b0, "high level idle");
        pulse_event(0);
        check(intr_pin, 1'b1, "high level active");
        rd(PCD_OFS_INT, 16'h7f01, "flag");
        wr(PCD_OFS_CTRL, 16'h0000);
        check(crossover_algorithm_select, 1'b0, "xsel low");
        rd(PCD_OFS_CTRL, 16'h0000, "ctrl cleared");
        wr(PCD_OFS_CTRL, 16'h8000);
    endtask : test_irq

    task automatic test_diag;
        logic [1:0] pr;
        logic [8:0] pc;
        int         s0;
        pr = 2'h0;
        pc = 9'h000;
        for (int r = 0; r < 4; r++) begin
            s0 = starts;
            wr(PCD_OFS_DIAG, 16'h9e00);
            check(16'(starts - s0), 16'h1, "start pulse");
            rd(PCD_OFS_DIAG, {1'b1, pr, 4'h0, pc}, "busy");
            wr(PCD_OFS_DIAG, 16'h8000);
            check(16'(starts - s0), 16'h1, "start while busy");
            pr = 2'(r);
            pc = 9'h100 + 9'(r * 37);
            @(posedge clk);
            cable_result      <= pr;
            cable_fault_count <= pc;
            cable_test_done   <= 1'b1;
            @(posedge clk);
            cable_test_done <= 1'b0;
            rd(PCD_OFS_DIAG, {1'b0, pr, 4'h0, pc}, "result");
        end
        wr(PCD_OFS_DIAG, 16'h1e00);
        check(16'(starts - s0), 16'h1, "reserved write");
    endtask : test_diag

    task automatic test_xcvr;
        logic [4:0] stim [4] = '{5'b10110, 5'b11001, 5'b11101, 5'b11111};
        logic [3:0] exp  [4] = '{4'b1101, 4'b1011, 4'b1110, 4'b0000};
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            @(posedge clk);
            {link_up, activity, full_duplex, collision, speed_100} <= stim[i];
            polarity_reversed <= m[0];
            far_end_fault     <= m[1];
            mdi_state         <= ~m[0];
            wr(PCD_OFS_XCVR, {m, 6'h3f, m[0], 7'h7f});
            rd(PCD_OFS_XCVR, {m, m[0], ~m[1], ~m[0], 3'h0, m[0], 7'h00}, "xcvr");
            check(ind, exp[i], "indicators");
            check(remote_loopback, m[0], "loopback");
        end
    endtask : test_xcvr

    task automatic test_refused;
        wr(PCD_OFS_XCVR, 16'h0000, 5'h02);
        rd(PCD_OFS_XCVR, 16'he080, "other address write");
        rd(PCD_OFS_XCVR, 16'hffff, "other address read", 5'h02);
        wr(5'h10, 16'hffff);
        rd(5'h10, 16'h0000, "unmapped");
    endtask : test_refused

    task automatic stop_test;
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        stop_test();
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        event_in = 8'h00;
        {cable_test_done, cable_result, cable_fault_count} = 12'h000;
        {polarity_reversed, far_end_fault, mdi_state} = 3'h0;
        {link_up, activity, full_duplex, collision, speed_100} = 5'h00;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        test_reset();
        test_irq();
        test_diag();
        test_xcvr();
        test_refused();
        stop_test();
    end
endmodule : pcd_regs_tb
